// ==== logic/buck_mode_and_core_voltage_scaling.sv ====
/*
 * mode, phase and discharge control for three step-down converters, plus the
 * core converter voltage ramp sequencer, behind an 8-bit register port.
 * assumes a serial front end on link_clk_i hands over one register request at
 * a time; supervisor pins arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none

module buck_mode_and_core_voltage_scaling #(
   parameter int CLK_PERIOD_NS = buck_ctrl_pkg::CLK_PERIOD_NS
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic link_clk_i,
   input wire logic link_rst_i,
   input wire logic req_valid_i,
   input wire buck_ctrl_pkg::reg_req_t req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [7:0] rsp_data_o,
   input wire logic undervoltage_lockout_i,
   input wire logic warm_restart_input_n_i,
   input wire logic power_on_reset_output_i,
   input wire logic backup_supply_low_i,
   input wire logic core_default_pin_i,
   output buck_ctrl_pkg::conv_ctrl_t conv_ctrl_o,
   output logic [1:0] phase_first_o,
   output logic core_pin_control_o,
   output logic [4:0] core_code_o,
   output logic [10:0] core_millivolt_o,
   output logic transition_busy_o
);
   // --------
   // elaboration checks
   // --------
   // the step counter is 12 bits wide; the slowest ramp must fit in it
   if (CLK_PERIOD_NS < 1 || buck_ctrl_pkg::ramp_cycles(0, CLK_PERIOD_NS) > 4095) begin : g_chk
      $error("clock period unusable for ramp step counter");
   end
   // --------
   // link domain: request capture and response
   // --------
   buck_ctrl_pkg::reg_req_t req_hold;  // held stable until the answer returns
   logic busy_l;                       // request in flight
   logic req_tog_l;                    // flips once per request
   logic ack_meta_l;                   // first sync stage, read by stage two only
   logic ack_sync_l;
   logic ack_seen_l;                   // last acknowledged toggle value
   logic ack_tog_r;                    // ref-domain acknowledge toggle
   logic [7:0] rdata_r;                // ref-domain read data, stable when acked

   // one request at a time keeps the held word stable across the crossing
   assign req_ready_o = !busy_l;

   // acknowledge toggle into the link domain
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         ack_meta_l <= 1'b0;
         ack_sync_l <= 1'b0;
      end else begin
         ack_meta_l <= ack_tog_r;
         ack_sync_l <= ack_meta_l;
      end
   end

   // take a request, wait for the acknowledge, present the answer
   always_ff @(posedge link_clk_i) begin
      if (link_rst_i) begin
         req_hold <= '0;
         busy_l <= 1'b0;
         req_tog_l <= 1'b0;
         ack_seen_l <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_data_o <= 8'h00;
      end else begin
         rsp_valid_o <= 1'b0;
         if (req_valid_i && !busy_l) begin
            // capture, then announce by toggling
            req_hold <= req_i;
            req_tog_l <= ~req_tog_l;
            busy_l <= 1'b1;
         end else if (busy_l && (ack_sync_l != ack_seen_l)) begin
            // rdata_r has not moved since the ack toggled
            ack_seen_l <= ack_sync_l;
            busy_l <= 1'b0;
            rsp_valid_o <= 1'b1;
            rsp_data_o <= rdata_r;
         end
      end
   end
   // --------
   // ref domain: synchronisers
   // --------
   logic req_meta;        // first stage, read by second only
   logic req_sync;
   logic req_seen;
   logic [4:0] pin_meta;  // first stage of supervisor pins
   logic [4:0] pin_sync;  // 0 lockout, 1 warm_n, 2 por, 3 backup low, 4 default
   logic new_req;

   // warm restart idles high, so its stages reset to one
   localparam logic [4:0] PIN_IDLE = 5'h02;

   // request toggle crossing
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end else if (ce_i) begin
         req_meta <= req_tog_l;
         req_sync <= req_meta;
      end
   end

   // supervisor and strap pins, two flops each
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_meta <= PIN_IDLE;
         pin_sync <= PIN_IDLE;
      end else if (ce_i) begin
         pin_meta <= {core_default_pin_i, backup_supply_low_i, power_on_reset_output_i,
                      warm_restart_input_n_i, undervoltage_lockout_i};
         pin_sync <= pin_meta;
      end
   end

   assign new_req = req_sync != req_seen;
   // --------
   // reset events
   // --------
   logic lockout;        // full register reload
   logic soft_event;     // reloads pin select and target only
   logic strap_high;     // default pin tied to supply
   logic [1:0] settle;   // counts until the strap is valid after reset
   logic reload;         // any event that reloads the target code
   logic [4:0] strap_code;
   logic [4:0] pin_code;
   assign lockout = pin_sync[0];
   assign soft_event = !pin_sync[1] || pin_sync[2] || pin_sync[3];
   assign strap_high = pin_sync[4];
   assign reload = lockout || soft_event || (settle != buck_ctrl_pkg::SETTLE_CYCLES);
   assign strap_code = strap_high ? buck_ctrl_pkg::TARGET_RST_PIN_HIGH
                                  : buck_ctrl_pkg::TARGET_RST_PIN_LOW;
   assign pin_code = strap_high ? buck_ctrl_pkg::PIN_CODE_VCC
                                : buck_ctrl_pkg::PIN_CODE_GND;

   // strap is caught only once the synchroniser has filled
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         settle <= 2'h0;
      end else if (ce_i && settle != buck_ctrl_pkg::SETTLE_CYCLES) begin
         settle <= settle + 2'h1;
      end
   end
   // --------
   // registers
   // --------
   logic [7:0] mode_phase;   // converter_mode_phase
   logic go;                 // transition_control bit 7
   logic pin_sel;            // transition_control bit 6
   logic [2:0] discharge;    // transition_control bits 2..0
   logic [4:0] target_code;  // core_target_code
   logic [2:0] ramp_code;    // ramp_rate_select
   logic done;               // internal code has reached target
   logic wr_mode;
   logic wr_trans;
   logic wr_target;
   logic wr_ramp;
   logic [7:0] wdata;
   assign wdata = req_hold.wdata;
   assign wr_mode = new_req && req_hold.write && req_hold.addr == buck_ctrl_pkg::MODE_PHASE_OFS;
   assign wr_trans = new_req && req_hold.write && req_hold.addr == buck_ctrl_pkg::TRANS_CTRL_OFS;
   assign wr_target = new_req && req_hold.write && req_hold.addr == buck_ctrl_pkg::TARGET_OFS;
   assign wr_ramp = new_req && req_hold.write && req_hold.addr == buck_ctrl_pkg::RAMP_OFS;

   // mode and phase register, reloaded only by lockout
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || (ce_i && lockout)) begin
         mode_phase <= buck_ctrl_pkg::MODE_PHASE_RST;
      end else if (ce_i && wr_mode) begin
         mode_phase <= wdata;
      end
   end

   // pin-control select, reloaded by all four events
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_sel <= buck_ctrl_pkg::TRANS_CTRL_RST[buck_ctrl_pkg::PIN_SEL_BIT];
      end else if (ce_i) begin
         if (lockout || soft_event) begin
            pin_sel <= buck_ctrl_pkg::TRANS_CTRL_RST[buck_ctrl_pkg::PIN_SEL_BIT];
         end else if (wr_trans) begin
            pin_sel <= wdata[buck_ctrl_pkg::PIN_SEL_BIT];
         end
      end
   end

   // discharge enables, reloaded by lockout
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || (ce_i && lockout)) begin
         discharge <= buck_ctrl_pkg::TRANS_CTRL_RST[2:0];
      end else if (ce_i && wr_trans) begin
         discharge <= wdata[2:0];
      end
   end

   // go bit: a write of one wins over completion in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || (ce_i && lockout)) begin
         go <= buck_ctrl_pkg::TRANS_CTRL_RST[buck_ctrl_pkg::GO_BIT];
      end else if (ce_i) begin
         if (wr_trans && wdata[buck_ctrl_pkg::GO_BIT]) begin
            go <= 1'b1;
         end else if (done) begin
            go <= 1'b0;
         end
         // writing zero leaves a running transition alone
      end
   end

   // core target code, reloaded from the strap on every event
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         target_code <= buck_ctrl_pkg::TARGET_RST_PIN_LOW;
      end else if (ce_i) begin
         if (reload) begin
            target_code <= strap_code;
         end else if (wr_target) begin
            target_code <= wdata[4:0];
         end
      end
   end

   // ramp rate code, reloaded by lockout
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || (ce_i && lockout)) begin
         ramp_code <= buck_ctrl_pkg::RAMP_RST;
      end else if (ce_i && wr_ramp) begin
         ramp_code <= wdata[2:0];
      end
   end
   // --------
   // read path and acknowledge
   // --------
   logic [7:0] read_value;

   // unmapped offsets read zero
   always_comb begin
      case (req_hold.addr)
         buck_ctrl_pkg::MODE_PHASE_OFS: read_value = mode_phase;
         buck_ctrl_pkg::TRANS_CTRL_OFS: read_value = {go, pin_sel, 3'h0, discharge} &
                                                     buck_ctrl_pkg::TRANS_RW_MASK;
         buck_ctrl_pkg::TARGET_OFS: read_value = {3'h0, target_code};
         buck_ctrl_pkg::RAMP_OFS: read_value = {5'h00, ramp_code};
         default: read_value = 8'h00;
      endcase
   end

   // reads see the value before any write of the same request
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         req_seen <= 1'b0;
         ack_tog_r <= 1'b0;
         rdata_r <= 8'h00;
      end else if (ce_i && new_req) begin
         req_seen <= req_sync;
         ack_tog_r <= ~ack_tog_r;
         rdata_r <= read_value;
      end
   end
   // --------
   // voltage ramp sequencer
   // --------
   logic [4:0] core_code;    // internal code the converter follows
   logic [4:0] eff_target;   // where the ramp is heading
   logic [11:0] step_cnt;    // cycles left before the next step
   logic [11:0] step_reload;
   assign eff_target = pin_sel ? pin_code : target_code;
   assign done = go && (core_code == eff_target);

   // interval per 25 mV step; rate doubles with each code
   always_comb begin
      step_reload = 12'(buck_ctrl_pkg::ramp_cycles(int'(ramp_code), CLK_PERIOD_NS) - 1);
   end

   // step once per interval; immediate code jumps straight to the target
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         core_code <= buck_ctrl_pkg::PIN_CODE_GND;
         step_cnt <= 12'h000;
      end else if (ce_i) begin
         if (!go) begin
            step_cnt <= step_reload;
            if (pin_sel) begin
               core_code <= pin_code;
            end
         end else if (core_code != eff_target) begin
            if (ramp_code == buck_ctrl_pkg::RAMP_IMMEDIATE) begin
               core_code <= eff_target;
            end else if (step_cnt == 12'h000) begin
               step_cnt <= step_reload;
               if (core_code < eff_target) begin
                  core_code <= core_code + 5'h01;
               end else begin
                  core_code <= core_code - 5'h01;
               end
            end else begin
               step_cnt <= step_cnt - 12'h001;
            end
         end
      end
   end

   // code to millivolts for observation
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         core_millivolt_o <= 11'(buck_ctrl_pkg::MV_BASE);
      end else if (ce_i) begin
         if (core_code == buck_ctrl_pkg::TOP_CODE) begin
            core_millivolt_o <= 11'(buck_ctrl_pkg::MV_TOP);
         end else begin
            core_millivolt_o <= 11'(buck_ctrl_pkg::MV_BASE +
                                    buck_ctrl_pkg::MV_STEP * int'(core_code));
         end
      end
   end
   // --------
   // converter controls
   // --------
   assign phase_first_o = 2'h0;
   assign conv_ctrl_o.phase_second = mode_phase[buck_ctrl_pkg::PHASE_SECOND_LSB +: 2];
   assign conv_ctrl_o.phase_third = mode_phase[buck_ctrl_pkg::PHASE_THIRD_LSB +: 2];
   assign conv_ctrl_o.low_ripple = mode_phase[buck_ctrl_pkg::LOW_RIPPLE_BIT];

   // scatter the per-converter bits to converter order
   for (genvar c = 0; c < 3; c++) begin : g_conv
      assign conv_ctrl_o.forced_fixed_frequency[c] = mode_phase[buck_ctrl_pkg::CONV_BIT[c]];
      assign conv_ctrl_o.discharge_en[c] = discharge[buck_ctrl_pkg::CONV_BIT[c]];
   end

   assign core_pin_control_o = pin_sel;
   assign core_code_o = core_code;
   assign transition_busy_o = go;

endmodule

`default_nettype wire

// ==== logic/buck_ctrl_pkg.sv ====
/*
 * shared constants and types for the buck mode and core voltage scaling block:
 * register offsets, reset values, field positions, ramp timing and carriers.
 * assumes the registers are reached through an 8-bit register port that the
 * serial front end drives; nothing here holds state.
 */
`default_nettype none

package buck_ctrl_pkg;

   // --------
   // register offsets
   // --------
   localparam logic [7:0] MODE_PHASE_OFS = 8'h04;  // converter_mode_phase
   localparam logic [7:0] TRANS_CTRL_OFS = 8'h05;  // transition_control
   localparam logic [7:0] TARGET_OFS = 8'h06;      // core_target_code
   localparam logic [7:0] RAMP_OFS = 8'h07;        // ramp_rate_select

   // --------
   // reset values
   // --------
   localparam logic [7:0] MODE_PHASE_RST = 8'hb1;
   localparam logic [7:0] TRANS_CTRL_RST = 8'h40;
   localparam logic [2:0] RAMP_RST = 3'h6;
   localparam logic [4:0] TARGET_RST_PIN_LOW = 5'h14;   // default pin at ground
   localparam logic [4:0] TARGET_RST_PIN_HIGH = 5'h1e;  // default pin at supply

   // core code driven while pin control is selected
   localparam logic [4:0] PIN_CODE_GND = 5'h10;  // 1.2 V
   localparam logic [4:0] PIN_CODE_VCC = 5'h1f;  // 1.6 V

   // --------
   // field positions
   // --------
   localparam int PHASE_SECOND_LSB = 6;
   localparam int PHASE_THIRD_LSB = 4;
   localparam int LOW_RIPPLE_BIT = 3;
   localparam int GO_BIT = 7;
   localparam int PIN_SEL_BIT = 6;
   localparam logic [7:0] TRANS_RW_MASK = 8'hc7;  // bits 5..3 reserved
   // bit position per converter index: first, second, third
   localparam int CONV_BIT [3] = '{1, 2, 0};
   localparam logic [2:0] RAMP_IMMEDIATE = 3'h7;

   // --------
   // voltage code and ramp timing
   // --------
   localparam logic [4:0] TOP_CODE = 5'h1f;
   localparam int MV_BASE = 800;
   localparam int MV_STEP = 25;
   localparam int MV_TOP = 1600;
   localparam int STEP_UV = 25000;          // one code step, microvolts
   localparam int BASE_RATE_UV_PER_US = 225; // slowest ramp, code 000
   localparam int CLK_PERIOD_NS = 100;      // reference clock, 10 MHz
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] SETTLE_CYCLES = 2'h3; // pin syncs filled after reset

   // cycles per code step at a ramp code; rounded up so the rate is never
   // exceeded, never below one cycle
   function automatic int ramp_cycles(input int code, input int period_ns);
      int num;
      int den;
      num = STEP_UV * 1000;
      den = (BASE_RATE_UV_PER_US << code) * period_ns;
      ramp_cycles = (num + den - 1) / den;
      if (ramp_cycles < 1) begin
         ramp_cycles = 1;
      end
   endfunction

   // --------
   // carriers
   // --------
   typedef struct packed {
      logic write;        // 1 write, 0 read
      logic [7:0] addr;   // register offset
      logic [7:0] wdata;  // write data
   } reg_req_t;

   typedef struct packed {
      logic [1:0] phase_second;           // delay code of second converter
      logic [1:0] phase_third;            // delay code of third converter
      logic low_ripple;                   // pfm tuned for ripple
      logic [2:0] forced_fixed_frequency; // index 0 first, 1 second, 2 third
      logic [2:0] discharge_en;           // same indexing
   } conv_ctrl_t;

endpackage

`default_nettype wire

// ==== test/buck_ctrl_checker.sv ====
/* checker: port-level properties of the buck mode and core voltage block.
   assumes a bind onto the top module, with both clocks visible at its ports. */
`timescale 1ns/1ns
`default_nettype none
module buck_ctrl_checker (
   input wire logic ref_clk_i, input wire logic rst_i, input wire logic ce_i,
   input wire logic link_clk_i, input wire logic link_rst_i, input wire logic req_valid_i,
   input wire buck_ctrl_pkg::reg_req_t req_i, input wire logic req_ready_o,
   input wire logic rsp_valid_o, input wire logic [7:0] rsp_data_o,
   input wire logic undervoltage_lockout_i, input wire logic warm_restart_input_n_i,
   input wire logic power_on_reset_output_i, input wire logic backup_supply_low_i,
   input wire buck_ctrl_pkg::conv_ctrl_t conv_ctrl_o, input wire logic [1:0] phase_first_o,
   input wire logic core_pin_control_o, input wire logic [4:0] core_code_o,
   input wire logic [10:0] core_millivolt_o, input wire logic transition_busy_o
);
   // --------
   // helper state on the link side
   // --------
   buck_ctrl_pkg::reg_req_t held; // request now in flight
   logic [4:0] tgt; // last target written
   logic tgt_ok; // target known; any reload event forgets it
   logic take; // request taken at this edge
   assign take = req_valid_i & req_ready_o;
   // reload events rewrite the target behind our back, so drop it then
   always_ff @(posedge link_clk_i) begin
      if (take) begin
         held <= req_i;
      end
      if (link_rst_i || rst_i || undervoltage_lockout_i || !warm_restart_input_n_i
          || power_on_reset_output_i || backup_supply_low_i) begin
         tgt_ok <= 1'b0;
      end else if (take && req_i.write && req_i.addr == buck_ctrl_pkg::TARGET_OFS) begin
         tgt_ok <= 1'b1;
         tgt <= req_i.wdata[4:0];
      end
   end
   // millivolts of a code; the top code jumps to 1.6 V
   function automatic logic [10:0] mv_of(input logic [4:0] c);
      mv_of = (c == 5'h1f) ? 11'h640 : 11'h320 + 11'h19 * 11'(c);
   endfunction
   // --------
   // properties
   // --------
   sequence s_taken;
      req_valid_i && req_ready_o;
   endsequence
   sequence s_answer;
      ##[1:40] rsp_valid_o;
   endsequence
   sequence s_wrote(logic [7:0] a);
      rsp_valid_o && held.write && held.addr == a;
   endsequence
   property p_answer;
      @(posedge link_clk_i) disable iff (link_rst_i) s_taken |-> s_answer;
   endproperty
   a_answer: assert property (p_answer) else $error("request never answered");
   property p_phase;
      @(posedge link_clk_i) disable iff (link_rst_i) s_wrote(8'h04) |->
         conv_ctrl_o.phase_second == held.wdata[7:6] && conv_ctrl_o.phase_third == held.wdata[5:4];
   endproperty
   a_phase: assert property (p_phase) else $error("phase codes differ from write");
   property p_mode;
      @(posedge link_clk_i) disable iff (link_rst_i) s_wrote(8'h04) |->
         conv_ctrl_o.low_ripple == held.wdata[3] && conv_ctrl_o.forced_fixed_frequency
         == {held.wdata[0], held.wdata[2], held.wdata[1]};
   endproperty
   a_mode: assert property (p_mode) else $error("mode bits differ from write");
   property p_discharge;
      @(posedge link_clk_i) disable iff (link_rst_i) s_wrote(8'h05) |->
         conv_ctrl_o.discharge_en == {held.wdata[0], held.wdata[2], held.wdata[1]}
         && core_pin_control_o == held.wdata[6];
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge or source wrong");
   property p_reserved;
      @(posedge link_clk_i) disable iff (link_rst_i)
         rsp_valid_o && !held.write && held.addr == 8'h05 |-> rsp_data_o[5:3] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
   property p_phase_first;
      @(posedge ref_clk_i) disable iff (rst_i) phase_first_o == 2'h0;
   endproperty
   a_phase_first: assert property (p_phase_first) else $error("first phase not zero");
   property p_mv;
      @(posedge ref_clk_i) disable iff (rst_i)
         !$past(rst_i) && $past(ce_i) |-> core_millivolt_o == mv_of($past(core_code_o));
   endproperty
   a_mv: assert property (p_mv) else $error("millivolts do not match code");
   property p_ramp_done;
      @(posedge ref_clk_i) disable iff (rst_i)
         $rose(transition_busy_o) |-> ##[1:1000] !transition_busy_o;
   endproperty
   a_ramp_done: assert property (p_ramp_done) else $error("go bit never cleared");
   property p_done_target;
      @(posedge ref_clk_i) disable iff (rst_i)
         $fell(transition_busy_o) && tgt_ok && !core_pin_control_o |-> core_code_o == tgt;
   endproperty
   a_done_target: assert property (p_done_target) else $error("go cleared off target");
endmodule
`default_nettype wire

// ==== test/host_port_model.sv ====
/* host model: issues one register request at a time on the byte port.
   assumes the port answers every taken request with a one-cycle pulse. */
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
   input wire logic link_clk_i,
   input wire logic req_ready_i,
   input wire logic rsp_valid_i,
   output logic req_valid_o,
   output buck_ctrl_pkg::reg_req_t req_o
);
   initial begin
      req_valid_o = 1'b0;
      req_o = '1;
   end
   // present after a falling edge, hold until taken, then await the pulse
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic ok);
      int n;
      ok = 1'b0;
      @(negedge link_clk_i);
      req_o = {wr, a, d};
      req_valid_o = 1'b1;
      for (n = 0; n < 40 && req_ready_i !== 1'b1; n++) begin
         @(negedge link_clk_i);
      end
      // ready is a link-side level, so the rising edge between took it
      @(negedge link_clk_i);
      req_valid_o = 1'b0;
      req_o = ~req_o; // released: never the last value
      for (n = 0; n < 40 && !ok; n++) begin
         @(negedge link_clk_i);
         ok = (rsp_valid_i === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// ==== test/buck_mode_and_core_voltage_scaling_test.sv ====
/* top bench: resets the block, drives registers through the host model and
   the supervisor events, and checks answers and core outputs.
   assumes the package, design, checker and host model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module buck_mode_and_core_voltage_scaling_test;
   // --------
   // signals and bench state
   // --------
   localparam int PERIOD = 10000; // stretched period: code 0 steps every 12 cycles
   logic ref_clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1; // low freezes the reference side
   logic core_default_pin_i = 1'b0;
   logic [3:0] evt = 4'h0; // warm restart, power-on reset, backup low, lockout
   logic req_valid_i;
   buck_ctrl_pkg::reg_req_t req_i;
   logic req_ready_o;
   logic rsp_valid_o;
   logic [7:0] rsp_data_o;
   buck_ctrl_pkg::conv_ctrl_t conv_ctrl_o;
   logic [1:0] phase_first_o;
   logic core_pin_control_o;
   logic [4:0] core_code_o;
   logic [10:0] core_millivolt_o;
   logic transition_busy_o;
   logic [8:0] expq [$]; // pending answers: check flag, expected byte
   logic [8:0] e;
   logic [7:0] d;
   logic [4:0] t;
   logic [4:0] cur = 5'h1f; // core code left by the event scenario
   logic [7:0] ofs [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09};
   logic [7:0] rstv [5] = '{8'hb1, 8'h40, 8'h14, 8'h06, 8'h00};
   int num_errors = 0;
   int tests_run = 0;
   int seed = 21;
   int i;
   int n;
   int total;
   always #50 ref_clk_i = ~ref_clk_i;
   always #16 link_clk_i = ~link_clk_i;
   buck_mode_and_core_voltage_scaling #(.CLK_PERIOD_NS(PERIOD)) DUT (.*,
      .link_rst_i(rst_i), .warm_restart_input_n_i(~evt[0]), .power_on_reset_output_i(evt[1]),
      .backup_supply_low_i(evt[2]), .undervoltage_lockout_i(evt[3]));
   host_port_model u_host (.link_clk_i(link_clk_i), .req_ready_i(req_ready_o),
      .rsp_valid_i(rsp_valid_o), .req_valid_o(req_valid_i), .req_o(req_i));
   // --------
   // tasks
   // --------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one transfer; the expected answer is noted before the request goes out
   task automatic xf(input logic wr, input logic [7:0] a, input logic [7:0] dd,
                     input logic chk, input logic [7:0] ex);
      logic ok;
      expq.push_back({chk, ex});
      u_host.xfer(wr, a, dd, ok);
      if (ok !== 1'b1) begin
         num_errors++;
         print_verdict();
      end
   endtask
   // answers are compared as they appear, oldest note first
   always @(negedge link_clk_i) begin
      if (rsp_valid_o === 1'b1) begin
         if (expq.size() == 0) begin
            num_errors++;
         end else begin
            e = expq.pop_front();
            if (e[8]) begin
               check(16'(rsp_data_o), 16'(e[7:0]));
            end
         end
      end
   end
   // --------
   // main sequence
   // --------
   initial begin
      repeat (6) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (10) @(negedge ref_clk_i);
      // reset values, an unmapped offset reading zero
      for (i = 0; i < 5; i++) begin
         xf(1'b0, ofs[i], 8'h00, 1'b1, rstv[i]);
      end
      check(16'(core_code_o), 16'h10);
      check(16'(core_millivolt_o), 16'h4b0);
      // each reload event, strap alternating
      for (i = 0; i < 4; i++) begin
         core_default_pin_i = i[0];
         xf(1'b1, 8'h05, 8'h00, 1'b0, 8'h00);
         xf(1'b1, 8'h06, 8'h03, 1'b0, 8'h00);
         xf(1'b1, 8'h04, 8'h00, 1'b0, 8'h00);
         evt[i] = 1'b1;
         repeat (6) @(negedge ref_clk_i);
         evt[i] = 1'b0;
         repeat (6) @(negedge ref_clk_i);
         xf(1'b0, 8'h05, 8'h00, 1'b1, 8'h40);
         xf(1'b0, 8'h06, 8'h00, 1'b1, i[0] ? 8'h1e : 8'h14);
         xf(1'b0, 8'h04, 8'h00, 1'b1, (i == 3) ? 8'hb1 : 8'h00);
         check(16'(core_code_o), i[0] ? 16'h1f : 16'h10);
      end
      // random mode, phase and discharge settings; go kept clear
      for (i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         xf(1'b1, 8'h04, d, 1'b0, 8'h00);
         xf(1'b0, 8'h04, 8'h00, 1'b1, d);
         xf(1'b1, 8'h05, d & 8'h7f, 1'b0, 8'h00);
         xf(1'b0, 8'h05, 8'h00, 1'b1, d & 8'h47);
      end
      // one ramp for every slew code, to a random target
      xf(1'b1, 8'h05, 8'h00, 1'b0, 8'h00);
      for (i = 0; i < 8; i++) begin
         t = 5'($random(seed));
         xf(1'b1, 8'h07, {5'h1f, i[2:0]}, 1'b0, 8'h00);
         xf(1'b0, 8'h07, 8'h00, 1'b1, {5'h00, i[2:0]});
         xf(1'b1, 8'h06, {3'h7, t}, 1'b0, 8'h00);
         total = (t > cur) ? int'(t - cur) : int'(cur - t);
         total = (i == 7) ? 0 : total * ((2500 + (225 << i) - 1) / (225 << i));
         xf(1'b1, 8'h05, 8'h80, 1'b1, 8'h00);
         for (n = 0; n < 2000 && transition_busy_o !== 1'b0; n++) begin
            @(negedge ref_clk_i);
         end
         check(16'(n <= total + 2 && n + 6 >= total), 16'h1);
         check(16'(core_code_o), 16'(t));
         repeat (2) @(negedge ref_clk_i);
         check(16'(core_millivolt_o), (t == 5'h1f) ? 16'h640 : 16'h320 + 16'h19 * t);
         xf(1'b0, 8'h05, 8'h00, 1'b1, 8'h00);
         cur = t;
      end
      // a zero go write leaves the core code alone
      xf(1'b1, 8'h06, {3'h0, ~cur}, 1'b0, 8'h00);
      xf(1'b1, 8'h05, 8'h00, 1'b0, 8'h00);
      repeat (40) @(negedge ref_clk_i);
      check(16'(core_code_o), 16'(cur));
      // a frozen block misses a lockout pulse, so the ramp code stays
      @(negedge ref_clk_i);
      ce_i = 1'b0;
      evt[3] = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      evt[3] = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      ce_i = 1'b1;
      xf(1'b0, 8'h07, 8'h00, 1'b1, 8'h07);
      print_verdict();
   end
endmodule
bind buck_mode_and_core_voltage_scaling buck_ctrl_checker u_chk (.*);
`default_nettype wire
